// ### shared/bps_pkg.sv
/*
 * shared constants for the bridge parity status block: register map,
 * field positions, reset values and transaction codes.
 * assumes a 32-bit classic wishbone register port, byte addressed.
 */
package bps_pkg;

   // register byte offsets
   localparam logic [7:0] BPS_CTRL_OFS   = 8'h00;
   localparam logic [7:0] BPS_STAT_OFS   = 8'h04;
   localparam logic [7:0] BPS_MASK_OFS   = 8'h08;
   localparam logic [7:0] BPS_STATE_OFS  = 8'h0c;

   // control fields
   localparam int BPS_CTRL_PRI_EN   = 0;
   localparam int BPS_CTRL_SEC_EN   = 1;
   localparam int BPS_CTRL_W        = 2;

   // status / mask fields
   localparam int BPS_ST_PRI_DET    = 0;
   localparam int BPS_ST_SEC_DET    = 1;
   localparam int BPS_ST_PRI_MDP    = 2;
   localparam int BPS_ST_SEC_MDP    = 3;
   localparam int BPS_ST_W          = 4;

   // state register fields
   localparam int BPS_SR_PRI_PIN    = 0;
   localparam int BPS_SR_SEC_PIN    = 1;
   localparam int BPS_SR_LAST_LO    = 4;
   localparam int BPS_SR_LAST_W     = 4;

   // reset values
   localparam logic [BPS_CTRL_W-1:0] BPS_CTRL_RST = 2'h0;
   localparam logic [BPS_ST_W-1:0]   BPS_STAT_RST = 4'h0;
   localparam logic [BPS_ST_W-1:0]   BPS_MASK_RST = 4'h0;

   // transaction type codes on the per-bus type inputs
   localparam logic [1:0] BPS_TXN_READ    = 2'h0;
   localparam logic [1:0] BPS_TXN_POSTED  = 2'h1;
   localparam logic [1:0] BPS_TXN_DELAYED = 2'h2;
   localparam logic [1:0] BPS_TXN_NONE    = 2'h3;

   // synchroniser depth for pins
   localparam int BPS_SYNC_STAGES = 2;

endpackage

// ### hw/bps_sync.sv
/*
 * two-flop level synchroniser for one asynchronous pin.
 * assumes the pin is idle high; the chain resets to the idle level.
 */
module bps_sync
   import bps_pkg::*;
(
   input  wire logic mclk,     // block clock
   input  wire logic rst_n,    // async reset, active low
   input  wire logic pin_in,   // raw pin level
   output logic      pin_out   // synchronised level
);

   logic [BPS_SYNC_STAGES-1:0] chain_q;
   logic [BPS_SYNC_STAGES-1:0] chain_d;

   always_comb begin
      chain_d = {chain_q[BPS_SYNC_STAGES-2:0], pin_in};
   end

   // idle level is high, so reset to ones
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         chain_q <= '1;
      end else begin
         chain_q <= chain_d;
      end
   end

   assign pin_out = chain_q[BPS_SYNC_STAGES-1];

endmodule

// ### hw/bps_stat_bit.sv
/*
 * one sticky status flag: set by a hardware event, cleared by a
 * software write of one. assumes set and clear on the same clock.
 */
module bps_stat_bit (
   input  wire logic mclk,    // block clock
   input  wire logic rst_n,   // async reset, active low
   input  wire logic set_i,   // hardware event
   input  wire logic clr_i,   // software write-one-to-clear
   output logic      flag_q   // sticky flag
);

   logic flag_d;

   // set wins over clear so a coincident event is kept
   always_comb begin
      flag_d = flag_q;
      if (clr_i) begin
         flag_d = 1'b0;
      end
      if (set_i) begin
         flag_d = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

endmodule

// ### hw/bps_top.sv
/*
 * parity status logic of a two-port bridge: decides when the four
 * data-parity status flags are set, holds them as write-one-to-clear
 * bits behind a classic wishbone slave, and raises a masked interrupt.
 * assumes both bus interfaces' parity checkers and transaction
 * trackers run on mclk; the two parity-error pins are asynchronous.
 */
// The Wishbone register port and the placing of the registers were left to the implementer.
// Overview of operation
// - A primary-bus data parity error sets the primary detected flag whatever the enables.
// - The primary detected flag sets only for upstream reads and downstream posted or delayed writes.
// - A secondary-bus data parity error sets the secondary detected flag whatever the enables.
// - The secondary detected flag sets only for downstream reads and upstream posted or delayed writes.
// - The primary master parity flag sets only while the block masters the primary bus.
// - The primary master parity flag needs the primary response enable and ignores the secondary one.
// - The primary master flag sets on a sampled primary error pin or primary parity error, upstream only.
// - The secondary master parity flag sets only while the block masters the secondary bus.
// - The secondary master parity flag needs the secondary response enable.
// - The secondary master flag sets on a sampled secondary error pin or secondary parity error.
module bps_top
   import bps_pkg::*;
(
   input  wire logic        mclk,                   // block clock
   input  wire logic        rst_n,                  // async reset
   // wishbone classic slave
   input  wire logic        wb_cyc_i,               // cycle
   input  wire logic        wb_stb_i,               // strobe
   input  wire logic        wb_we_i,                // write enable
   input  wire logic [7:0]  wb_adr_i,               // byte address
   input  wire logic [3:0]  wb_sel_i,               // byte selects
   input  wire logic [31:0] wb_dat_i,               // write data
   output logic [31:0]      wb_dat_o,               // read data
   output logic             wb_ack_o,               // acknowledge
   // primary bus interface
   input  wire logic        pri_dperr,              // parity err seen
   input  wire logic [1:0]  pri_txn_type,           // transaction code
   input  wire logic        pri_txn_up,             // 1 = upstream
   input  wire logic        pri_is_master,          // block masters bus
   input  wire logic        primary_parity_err_n,   // error pin, async
   // secondary bus interface
   input  wire logic        sec_dperr,              // parity err seen
   input  wire logic [1:0]  sec_txn_type,           // transaction code
   input  wire logic        sec_txn_up,             // 1 = upstream
   input  wire logic        sec_is_master,          // block masters bus
   input  wire logic        secondary_parity_err_n, // error pin, async
   // status outputs
   output logic             pri_resp_en,            // primary enable
   output logic             sec_resp_en,            // secondary enable
   output logic [3:0]       parity_status,          // sticky flags
   output logic             irq                     // level interrupt
);

   // detected-error cases: reads in one direction, writes in the other
   function automatic logic det_case(input logic [1:0] typ,
                                     input logic       up,
                                     input logic       read_up);
      logic is_rd;
      logic is_wr;
      is_rd = (typ == BPS_TXN_READ);
      is_wr = (typ == BPS_TXN_POSTED) || (typ == BPS_TXN_DELAYED);
      return (is_rd && (up == read_up)) || (is_wr && (up != read_up));
   endfunction

   // any real transaction code
   function automatic logic txn_valid(input logic [1:0] typ);
      return typ != BPS_TXN_NONE;
   endfunction

   logic                  pri_pin_n;
   logic                  sec_pin_n;
   logic [BPS_ST_W-1:0]   ev_set;
   logic [BPS_ST_W-1:0]   st_clr;
   logic [BPS_ST_W-1:0]   stat_q;

   logic [BPS_CTRL_W-1:0] ctrl_q;
   logic [BPS_CTRL_W-1:0] ctrl_d;
   logic [BPS_ST_W-1:0]   mask_q;
   logic [BPS_ST_W-1:0]   mask_d;
   logic [BPS_SR_LAST_W-1:0] last_q;
   logic [BPS_SR_LAST_W-1:0] last_d;

   logic                  ack_q;
   logic                  ack_d;
   logic [31:0]           rdat_q;
   logic [31:0]           rdat_d;
   logic                  wr_take;
   logic                  rd_take;

   // pins come from other agents' clocks, so resync before use
   bps_sync u_pri_sync (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .pin_in  (primary_parity_err_n),
      .pin_out (pri_pin_n)
   );

   bps_sync u_sec_sync (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .pin_in  (secondary_parity_err_n),
      .pin_out (sec_pin_n)
   );

   // status events
   always_comb begin
      ev_set = '0;
      // enables deliberately not looked at here
      ev_set[BPS_ST_PRI_DET] = pri_dperr &&
         det_case(pri_txn_type, pri_txn_up, 1'b1);
      ev_set[BPS_ST_SEC_DET] = sec_dperr &&
         det_case(sec_txn_type, sec_txn_up, 1'b0);
      // target reports bad write parity on its pin
      ev_set[BPS_ST_PRI_MDP] = pri_is_master
         && ctrl_q[BPS_CTRL_PRI_EN]
         && pri_txn_up && txn_valid(pri_txn_type)
         && (!pri_pin_n || pri_dperr);
      ev_set[BPS_ST_SEC_MDP] = sec_is_master
         && ctrl_q[BPS_CTRL_SEC_EN]
         && !sec_txn_up && txn_valid(sec_txn_type)
         && (!sec_pin_n || sec_dperr);
   end

   // wishbone handshake: ack one cycle after the request is seen,
   // write lands on the edge that samples ack
   assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
   assign rd_take = wb_cyc_i && wb_stb_i && !ack_q;

   always_comb begin
      st_clr = '0;
      if (wr_take && wb_sel_i[0] && (wb_adr_i == BPS_STAT_OFS)) begin
         st_clr = wb_dat_i[BPS_ST_W-1:0];
      end
   end

   // sticky flags, each set on the edge its error is sampled
   genvar gi;
   generate
      for (gi = 0; gi < BPS_ST_W; gi++) begin : g_stat
         bps_stat_bit u_bit (
            .mclk   (mclk),
            .rst_n  (rst_n),
            .set_i  (ev_set[gi]),
            .clr_i  (st_clr[gi]),
            .flag_q (stat_q[gi])
         );
      end
   endgenerate

   // control, mask and last-event capture
   always_comb begin
      ctrl_d = ctrl_q;
      mask_d = mask_q;
      last_d = last_q;
      if (wr_take && wb_sel_i[0]) begin
         if (wb_adr_i == BPS_CTRL_OFS) begin
            ctrl_d = wb_dat_i[BPS_CTRL_W-1:0];
         end
         if (wb_adr_i == BPS_MASK_OFS) begin
            mask_d = wb_dat_i[BPS_ST_W-1:0];
         end
      end
      // remembers which flags the latest event cycle raised
      if (|ev_set) begin
         last_d = ev_set;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= BPS_CTRL_RST;
         mask_q <= BPS_MASK_RST;
         last_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         mask_q <= mask_d;
         last_q <= last_d;
      end
   end

   // read path; unmapped offsets read zero and still ack
   always_comb begin
      ack_d  = rd_take;
      rdat_d = rdat_q;
      if (rd_take) begin
         rdat_d = '0;
         unique case (wb_adr_i)
            BPS_CTRL_OFS: begin
               rdat_d[BPS_CTRL_W-1:0] = ctrl_q;
            end
            BPS_STAT_OFS: begin
               rdat_d[BPS_ST_W-1:0] = stat_q;
            end
            BPS_MASK_OFS: begin
               rdat_d[BPS_ST_W-1:0] = mask_q;
            end
            BPS_STATE_OFS: begin
               rdat_d[BPS_SR_PRI_PIN] = !pri_pin_n;
               rdat_d[BPS_SR_SEC_PIN] = !sec_pin_n;
               rdat_d[BPS_SR_LAST_LO +: BPS_SR_LAST_W] = last_q;
            end
            default: begin
               rdat_d = '0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q  <= 1'b0;
         rdat_q <= '0;
      end else begin
         ack_q  <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   assign wb_ack_o      = ack_q;
   assign wb_dat_o      = rdat_q;
   assign pri_resp_en   = ctrl_q[BPS_CTRL_PRI_EN];
   assign sec_resp_en   = ctrl_q[BPS_CTRL_SEC_EN];
   assign parity_status = stat_q;
   // level stays up until every unmasked flag is cleared
   assign irq           = |(stat_q & mask_q);

endmodule

// ### verification/bps_top_asserts.sv
/*
 * concurrent checks on the four parity flags of bps_top.
 * assumes it is bound to bps_top and everything runs on mclk.
 */
module bps_top_asserts
   import bps_pkg::*;
(
   input wire logic       mclk,          // clock
   input wire logic       rst_n,         // async reset
   input wire logic       wb_cyc_i,      // cycle
   input wire logic       wb_stb_i,      // strobe
   input wire logic       wb_we_i,       // write
   input wire logic [7:0] wb_adr_i,      // address
   input wire logic [3:0] wb_sel_i,      // selects
   input wire logic [31:0] wb_dat_i,     // write data
   input wire logic       wb_ack_o,      // ack
   input wire logic       pri_dperr,     // primary error
   input wire logic [1:0] pri_txn_type,  // primary code
   input wire logic       pri_txn_up,    // primary dir
   input wire logic       pri_is_master, // primary master
   input wire logic       sec_dperr,     // secondary error
   input wire logic [1:0] sec_txn_type,  // secondary code
   input wire logic       sec_txn_up,    // secondary dir
   input wire logic       sec_is_master, // secondary master
   input wire logic       pri_resp_en,   // primary enable
   input wire logic       sec_resp_en,   // secondary enable
   input wire logic [3:0] parity_status  // flags
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pd_ok, sd_ok, pm_ok, sm_ok, clr;
   assign pd_ok = (pri_txn_type == BPS_TXN_READ) ? pri_txn_up :
                  (pri_txn_type != BPS_TXN_NONE) && !pri_txn_up;
   assign sd_ok = (sec_txn_type == BPS_TXN_READ) ? !sec_txn_up :
                  (sec_txn_type != BPS_TXN_NONE) && sec_txn_up;
   assign pm_ok = pri_is_master && pri_resp_en && pri_txn_up &&
                  pri_txn_type != BPS_TXN_NONE;
   assign sm_ok = sec_is_master && sec_resp_en && !sec_txn_up &&
                  sec_txn_type != BPS_TXN_NONE;
   assign clr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o &&
                wb_sel_i[0] && wb_adr_i == BPS_STAT_OFS;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_pri_det_set: assert property (pri_dperr && pd_ok |=>
      parity_status[0]) else $error("primary detected flag missed");
   a_pri_det_cause: assert property ($rose(parity_status[0]) |->
      $past(pri_dperr && pd_ok)) else $error("primary detected flag stray");
   a_sec_det_set: assert property (sec_dperr && sd_ok |=>
      parity_status[1]) else $error("secondary detected flag missed");
   a_sec_det_cause: assert property ($rose(parity_status[1]) |->
      $past(sec_dperr && sd_ok)) else $error("secondary detected flag stray");
   a_pri_mdp_set: assert property (pri_dperr && pm_ok |=>
      parity_status[2]) else $error("primary master flag missed");
   a_pri_mdp_cause: assert property ($rose(parity_status[2]) |->
      $past(pm_ok)) else $error("primary master flag stray");
   a_sec_mdp_set: assert property (sec_dperr && sm_ok |=>
      parity_status[3]) else $error("secondary master flag missed");
   a_sec_mdp_cause: assert property ($rose(parity_status[3]) |->
      $past(sm_ok)) else $error("secondary master flag stray");
   a_flag_sticky: assert property (($past(parity_status) & ~parity_status &
      ~($past(wb_dat_i[3:0]) & {4{$past(clr)}})) == 4'h0)
      else $error("flag fell without a write of one");
endmodule

bind bps_top bps_top_asserts i_bps_top_asserts (.mclk, .rst_n, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
   .pri_dperr, .pri_txn_type, .pri_txn_up, .pri_is_master, .sec_dperr,
   .sec_txn_type, .sec_txn_up, .sec_is_master, .pri_resp_en, .sec_resp_en,
   .parity_status);

// ### verification/bps_bus_model.sv
/*
 * one bus side: parity checker, transaction tracker and a target
 * with its error pin. assumes the pin has a pull-up, so idle is high.
 */
module bps_bus_model
   import bps_pkg::*;
(
   input  wire logic mclk,      // clock
   output logic      dperr,     // parity error seen
   output logic [1:0] txn_type, // transaction code
   output logic      txn_up,    // direction
   output logic      is_master, // block masters bus
   output logic      perr_n     // target error pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      dperr = 1'b0;
      txn_type = BPS_TXN_NONE;
      txn_up = 1'b0;
      is_master = 1'b0;
      perr_n = 1'b1;
   end
   // transaction held 4 edges so a pin report clears the 2-flop sync
   task automatic xfer(input logic [1:0] t, input logic u, m, de, pe);
      @(posedge mclk);
      txn_type <= t;
      txn_up <= u;
      is_master <= m;
      dperr <= de;
      perr_n <= !pe; // target reports bad write data
      @(posedge mclk);
      dperr <= 1'b0;
      repeat (3) @(posedge mclk);
      txn_type <= BPS_TXN_NONE;
      is_master <= 1'b0;
      perr_n <= 1'b1;
      repeat (3) @(posedge mclk);
   endtask
endmodule

// ### verification/test_bps_top.sv
/*
 * self-checking bench for bps_top: register access over wishbone,
 * flag decisions per bus, pin reports, sticky clear and interrupt.
 * assumes bps_bus_model drives each bus side.
 */
module test_bps_top;
   timeunit 1ns;
   timeprecision 1ps;
   import bps_pkg::*;
   logic mclk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0, ps, exp;
   logic [31:0] dat = 32'h0, dato, rd;
   logic ack, pen, sen, irq, p_de, s_de, p_up, s_up, p_ms, s_ms, p_n, s_n;
   logic [1:0] p_ty, s_ty;
   int fail_count = 0, checks = 0;
   always #20 mclk = ~mclk;
   bps_top i_bps_top (.mclk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(dato), .wb_ack_o(ack), .pri_dperr(p_de), .pri_txn_type(p_ty),
      .pri_txn_up(p_up), .pri_is_master(p_ms), .primary_parity_err_n(p_n),
      .sec_dperr(s_de), .sec_txn_type(s_ty), .sec_txn_up(s_up),
      .sec_is_master(s_ms), .secondary_parity_err_n(s_n),
      .pri_resp_en(pen), .sec_resp_en(sen), .parity_status(ps), .irq(irq));
   bps_bus_model i_bps_bus_model_pri (.mclk, .dperr(p_de), .txn_type(p_ty),
      .txn_up(p_up), .is_master(p_ms), .perr_n(p_n));
   bps_bus_model i_bps_bus_model_sec (.mclk, .dperr(s_de), .txn_type(s_ty),
      .txn_up(s_up), .is_master(s_ms), .perr_n(s_n));
   task conclude;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         $display("unexpected %s: expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hf;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = dato;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) begin
         fail_count++;
         conclude();
      end
      @(negedge mclk);
   endtask
   task bus(input int b, input logic [1:0] t, input logic u, m, de, pe);
      if (b == 0) i_bps_bus_model_pri.xfer(t, u, m, de, pe);
      else i_bps_bus_model_sec.xfer(t, u, m, de, pe);
      @(negedge mclk);
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      for (int a = 0; a < 5; a++) begin
         wb(1'b0, 8'(a * 4), 32'h0);
         chk("reset read", 32'h0, rd);
      end
      wb(1'b1, 8'h10, 32'hf);
      wb(1'b0, 8'h10, 32'h0);
      chk("unmapped read", 32'h0, rd);
      $display("test registers done");
      for (int c = 0; c < 4; c++) for (int m = 0; m < 2; m++)
      for (int t = 0; t < 4; t++) for (int u = 0; u < 2; u++)
      for (int b = 0; b < 2; b++) begin
         wb(1'b1, BPS_CTRL_OFS, 32'(c));
         chk("enables", 32'(c), {sen, pen});
         bus(b, 2'(t), u[0], m[0], 1'b1, 1'b0);
         // code 3 carries no transaction, so it must raise nothing
         exp[0] = t != 3 && b == 0 && (t == 0 ? u == 1 : u == 0);
         exp[1] = t != 3 && b == 1 && (t == 0 ? u == 0 : u == 1);
         exp[2] = t != 3 && b == 0 && m == 1 && c[0] && u == 1;
         exp[3] = t != 3 && b == 1 && m == 1 && c[1] && u == 0;
         chk("flags", 32'(exp), 32'(ps));
         wb(1'b1, BPS_STAT_OFS, 32'hf);
         chk("flags cleared", 32'h0, 32'(ps));
      end
      $display("test decisions done");
      // the sweep leaves both enables on; pin reports start disabled
      wb(1'b1, BPS_CTRL_OFS, 32'h0);
      for (int b = 0; b < 2; b++) begin
         bus(b, BPS_TXN_POSTED, b == 0, 1'b1, 1'b0, 1'b1);
         chk("pin flag", 32'h0, 32'(ps));
         wb(1'b1, BPS_CTRL_OFS, 32'h3);
         bus(b, BPS_TXN_POSTED, b == 0, 1'b1, 1'b0, 1'b1);
         chk("pin flag", b ? 32'h8 : 32'h4, 32'(ps));
         wb(1'b1, BPS_STAT_OFS, 32'hf);
         wb(1'b1, BPS_CTRL_OFS, 32'h0);
      end
      $display("test pins done");
      bus(0, BPS_TXN_READ, 1'b1, 1'b0, 1'b1, 1'b0);
      wb(1'b1, BPS_STAT_OFS, 32'h0);
      chk("held flag", 32'h1, 32'(ps));
      chk("irq masked", 32'h0, 32'(irq));
      wb(1'b0, BPS_STATE_OFS, 32'h0);
      chk("state read", 32'h10, rd);
      wb(1'b1, BPS_MASK_OFS, 32'h1);
      chk("irq", 32'h1, 32'(irq));
      wb(1'b0, BPS_STAT_OFS, 32'h0);
      chk("status read", 32'h1, rd);
      wb(1'b1, BPS_STAT_OFS, 32'h1);
      chk("flag cleared", 32'h0, 32'(ps));
      chk("irq cleared", 32'h0, 32'(irq));
      wb(1'b0, BPS_MASK_OFS, 32'h0);
      chk("mask read", 32'h1, rd);
      $display("test sticky done");
      conclude();
   end
endmodule
